// *** logic/tgc_defines.svh ***
// constants of the traffic generator and checker
`ifndef TGC_DEFINES_SVH
`define TGC_DEFINES_SVH
// ==========================================
// stream channels
`define WORD_W 16
`define NUM_CH 4
`define CH_DATA 0
`define CH_UFC 1
`define CH_NATIVE_FLOW_CTRL 2
`define CH_USER_K 3
// ==========================================
// lfsr: right-shift galois form, x^16+x^14+x^13+x^11+1
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400
// ==========================================
// apb register map (byte addresses)
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_ERR 12'h008
`define CTRL_RESET 4'hF
`define ERR_CNT_MAX 8'hFF
`define ERR_UFC_BIT 8
`define ERR_USER_K_BIT 9
`define ERR_NATIVE_FLOW_CTRL_BIT 10
`define ERR_CLR_CNT_BIT 0
`define STAT_CHAN_UP_BIT 0
`define STAT_HARD_BIT 1
`define STAT_SOFT_BIT 2
`define STAT_LANE_LSB 8
// ==========================================
// transceiver reset debounce, in init clock edges
`define DEB_LEN 4
`endif

// *** logic/tgc_pkg.sv ***
// types shared by the traffic generator and checker
`include "tgc_defines.svh"
package tgc_pkg;
  // one beat of a stream channel: valid and payload travel together
  typedef struct packed {
    logic valid;
    logic [`WORD_W-1:0] data;
  } stream_s;
endpackage : tgc_pkg

// *** logic/traffic_gen_check.sv ***
// traffic generator, checker and status wrapper around a serial link core
//
// How it works
// - a generator drives traffic on the data, user flow control, native flow control and user-K transmit channels.
// - each payload word comes from an lfsr that starts at a fixed seed after reset.
// - the generator runs from the user clock, the reset, channel-up and the per-channel enable bits of the control register.
// - a transmit channel advances its word only on cycles where valid and ready are both high.
// - the checker predicts receive data with the same lfsr polynomial and seed as the generator.
// - every accepted receive word on each of the four channels is compared with the prediction and flagged on mismatch.
// - an 8-bit count of mismatching data words is kept in the user clock domain.
// - an active-high user flow control error flag follows mismatches on that channel.
// - an active-high user-K error flag follows mismatches on that channel.
// - channel-up and the error status of the core are registered before reaching the outputs.
// - each transceiver lane gets its own registered lane-up output.
// - the transceiver reset passes a debouncer stepped by the init clock before it reaches the core.
`timescale 1ns/1ps
`default_nettype none
`include "tgc_defines.svh"

module traffic_gen_check #(
  parameter int LANES = 1
) (
  input wire logic SYS_CLK, // user clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic CORE_CHANNEL_UP, // channel-up from the core
  input wire logic CORE_HARD_ERR, // hard error from the core
  input wire logic CORE_SOFT_ERR, // soft error from the core
  input wire logic [LANES-1:0] CORE_LANE_UP, // lane-up per lane from the core
  output wire tgc_pkg::stream_s [`NUM_CH-1:0] TX_STREAM, // transmit channels to the core
  input wire logic [`NUM_CH-1:0] TX_READY, // ready per transmit channel
  input wire tgc_pkg::stream_s [`NUM_CH-1:0] RX_STREAM, // receive channels from the core
  input wire logic INIT_CLK, // slow init clock, sampled
  input wire logic PMA_INIT, // transceiver reset request, raw pin
  output logic PMA_INIT_CORE, // debounced transceiver reset to the core
  output logic CHANNEL_UP, // registered channel-up
  output logic HARD_ERR, // registered hard error
  output logic SOFT_ERR, // registered soft error
  output logic [LANES-1:0] LANE_UP, // registered lane-up per lane
  output logic [7:0] DATA_ERR_COUNT, // mismatching data words, saturating
  output logic UFC_ERR, // user flow control mismatch
  output logic USER_K_ERR, // user-K mismatch
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [`ADDR_W-1:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR // apb error on unmapped address
);

  // ==========================================
  // functions
  // right-shift galois step; generator and checker share this very step
  function automatic logic [`WORD_W-1:0] lfsr_next(input logic [`WORD_W-1:0] x);
    lfsr_next = x[0] ? ((x >> 1) ^ `LFSR_TAPS) : (x >> 1);
  endfunction : lfsr_next

  // exact byte address match: unaligned offsets read as unmapped
  function automatic logic addr_hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // ==========================================
  // status registering
  // one register stage keeps the core's status timing off the output pins
  logic chan_up_q;
  logic hard_q;
  logic soft_q;
  logic [LANES-1:0] lane_q;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      chan_up_q <= 1'b0;
      hard_q <= 1'b0;
      soft_q <= 1'b0;
      lane_q <= '0;
    end
    else
    begin
      chan_up_q <= CORE_CHANNEL_UP;
      hard_q <= CORE_HARD_ERR;
      soft_q <= CORE_SOFT_ERR;
      lane_q <= CORE_LANE_UP;
    end
  end

  assign CHANNEL_UP = chan_up_q;
  assign HARD_ERR = hard_q;
  assign SOFT_ERR = soft_q;
  assign LANE_UP = lane_q;

  // ==========================================
  // transceiver reset debounce
  // init clock is treated as a sampled pin: it must run well below the user clock
  // a level change needs every sample to agree, so short glitches never reach the core
  logic init_s1_q;
  logic init_s2_q;
  logic init_prev_q;
  logic pma_s1_q;
  logic pma_s2_q;
  logic [`DEB_LEN-1:0] deb_q;
  logic pma_out_q;
  wire init_rise_w = init_s2_q & ~init_prev_q;
  wire deb_all1_w = &deb_q;
  wire deb_all0_w = ~|deb_q;

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      init_s1_q <= 1'b0;
      init_s2_q <= 1'b0;
      init_prev_q <= 1'b0;
      pma_s1_q <= 1'b0;
      pma_s2_q <= 1'b0;
      deb_q <= '0;
      pma_out_q <= 1'b0;
    end
    else
    begin
      init_s1_q <= INIT_CLK;
      init_s2_q <= init_s1_q;
      init_prev_q <= init_s2_q;
      pma_s1_q <= PMA_INIT;
      pma_s2_q <= pma_s1_q;
      if (init_rise_w)
        deb_q <= {deb_q[`DEB_LEN-2:0], pma_s2_q};
      if (deb_all1_w)
        pma_out_q <= 1'b1;
      else if (deb_all0_w)
        pma_out_q <= 1'b0;
    end
  end

  assign PMA_INIT_CORE = pma_out_q;

  // ==========================================
  // apb slave
  logic [3:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  wire hit_ctrl_w = addr_hit(PADDR, `REG_CTRL);
  wire hit_stat_w = addr_hit(PADDR, `REG_STATUS);
  wire hit_err_w = addr_hit(PADDR, `REG_ERR);
  wire mapped_w = hit_ctrl_w | hit_stat_w | hit_err_w;
  wire setup_w = PSEL & ~PENABLE;
  wire wr_w = PSEL & PENABLE & pready_q & PWRITE;
  wire wr_ctrl_w = wr_w & hit_ctrl_w;
  wire wr_err_w = wr_w & hit_err_w;
  wire clr_cnt_w = wr_err_w & PWDATA[`ERR_CLR_CNT_BIT];
  wire clr_nfc_w = wr_err_w & PWDATA[`ERR_NATIVE_FLOW_CTRL_BIT];
  logic [31:0] stat_w;
  logic [31:0] err_w;
  logic [31:0] rd_w;
  logic [7:0] cnt_q;
  logic ufc_q;
  logic uk_q;
  logic nfc_q;

  always_comb
  begin
    stat_w = '0;
    stat_w[`STAT_CHAN_UP_BIT] = chan_up_q;
    stat_w[`STAT_HARD_BIT] = hard_q;
    stat_w[`STAT_SOFT_BIT] = soft_q;
    stat_w[`STAT_LANE_LSB +: LANES] = lane_q;
    err_w = '0;
    err_w[7:0] = cnt_q;
    err_w[`ERR_UFC_BIT] = ufc_q;
    err_w[`ERR_USER_K_BIT] = uk_q;
    err_w[`ERR_NATIVE_FLOW_CTRL_BIT] = nfc_q;
    if (hit_ctrl_w)
      rd_w = {28'h0000000, ctrl_q};
    else if (hit_stat_w)
      rd_w = stat_w;
    else if (hit_err_w)
      rd_w = err_w;
    else
      rd_w = 32'h00000000;
  end

  // read data is captured at setup so it stands through the whole access cycle
  // one-wait-free slave: ready is raised for the access cycle that follows setup
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      ctrl_q <= `CTRL_RESET;
    end
    else
    begin
      pready_q <= setup_w;
      pslverr_q <= setup_w & ~mapped_w;
      if (setup_w && !PWRITE)
        prdata_q <= rd_w;
      if (wr_ctrl_w)
        ctrl_q <= PWDATA[3:0];
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;

  // ==========================================
  // generator and checker, one slice per channel
  // per-channel mismatch, one cycle after the word arrives
  logic [`NUM_CH-1:0] mis_w;

  for (genvar i = 0; i < `NUM_CH; i++)
  begin : g_ch
    logic txv_q;
    logic [`WORD_W-1:0] gen_q;
    logic [`WORD_W-1:0] exp_q;
    logic mis_q;
    wire fire_w = txv_q & TX_READY[i];
    // valid may only drop after the pending beat was taken, or when channel-up is low
    wire txv_d = ctrl_q[i] | (txv_q & ~TX_READY[i]);
    // no ready goes back to the core: every valid receive beat while channel-up is high advances the prediction

    always_ff @(posedge SYS_CLK)
    begin
      if (!RST_N || !chan_up_q)
      begin
        txv_q <= 1'b0;
        gen_q <= `LFSR_SEED;
        exp_q <= `LFSR_SEED;
        mis_q <= 1'b0;
      end
      else
      begin
        txv_q <= txv_d;
        if (fire_w)
          gen_q <= lfsr_next(gen_q);
        if (RX_STREAM[i].valid)
        begin
          mis_q <= (RX_STREAM[i].data != exp_q);
          exp_q <= lfsr_next(exp_q);
        end
        else
          mis_q <= 1'b0;
      end
    end

    assign TX_STREAM[i] = '{valid: txv_q, data: gen_q};
    assign mis_w[i] = mis_q;
  end

  // ==========================================
  // error reporting
  // flags pulse one cycle per bad word; native flow control errors stay until cleared
  logic [7:0] cnt_d;
  logic nfc_d;
  wire cnt_sat_w = (cnt_q == `ERR_CNT_MAX);
  wire [7:0] cnt_inc_w = cnt_sat_w ? cnt_q : 8'(cnt_q + 8'h01);

  // a mismatch in the clearing cycle still counts: the set wins
  always_comb
  begin
    cnt_d = cnt_q;
    if (mis_w[`CH_DATA])
      cnt_d = clr_cnt_w ? 8'h01 : cnt_inc_w;
    else if (clr_cnt_w)
      cnt_d = 8'h00;
    nfc_d = nfc_q;
    if (mis_w[`CH_NATIVE_FLOW_CTRL])
      nfc_d = 1'b1;
    else if (clr_nfc_w)
      nfc_d = 1'b0;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      cnt_q <= '0;
      ufc_q <= 1'b0;
      uk_q <= 1'b0;
      nfc_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      ufc_q <= mis_w[`CH_UFC];
      uk_q <= mis_w[`CH_USER_K];
      nfc_q <= nfc_d;
    end
  end

  assign DATA_ERR_COUNT = cnt_q;
  assign UFC_ERR = ufc_q;
  assign USER_K_ERR = uk_q;

endmodule : traffic_gen_check
`default_nettype wire

// *** testbench/tgc_properties.sv ***
// port-level properties of the traffic generator and checker
`timescale 1ns/1ps
`default_nettype none
`include "tgc_defines.svh"
// ==========
// checker
module tgc_properties #(
  parameter int LANES = 1
) (
  input wire logic SYS_CLK, // clock
  input wire logic RST_N, // reset
  input wire logic CORE_CHANNEL_UP, // core up
  input wire logic CORE_HARD_ERR, // core hard
  input wire logic [LANES-1:0] CORE_LANE_UP, // core lanes
  input wire logic CHANNEL_UP, // up
  input wire logic HARD_ERR, // hard
  input wire logic [LANES-1:0] LANE_UP, // lanes
  input wire tgc_pkg::stream_s [`NUM_CH-1:0] TX_STREAM, // tx
  input wire logic [`NUM_CH-1:0] TX_READY, // ready
  input wire tgc_pkg::stream_s [`NUM_CH-1:0] RX_STREAM, // rx
  input wire logic [7:0] DATA_ERR_COUNT, // count
  input wire logic UFC_ERR, // ufc flag
  input wire logic USER_K_ERR, // user-K flag
  input wire logic PSEL // apb select
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire logic [3:0] tv = {TX_STREAM[3].valid, TX_STREAM[2].valid, TX_STREAM[1].valid, TX_STREAM[0].valid};
  function automatic logic [15:0] nx(input logic [15:0] x);
    return x[0] ? (x >> 1) ^ `LFSR_TAPS : x >> 1;
  endfunction : nx
  stat_copy_a: assert property ($past(RST_N) |-> {CHANNEL_UP, HARD_ERR, LANE_UP} ==
    $past({CORE_CHANNEL_UP, CORE_HARD_ERR, CORE_LANE_UP})) else $error("status copy wrong");
  tx_quiet_a: assert property (!CHANNEL_UP |=> tv == 4'h0) else $error("valid while down");
  tx_hold_a: assert property (tv[0] && !TX_READY[0] && CORE_CHANNEL_UP && CHANNEL_UP
    |=> $stable(TX_STREAM[0])) else $error("beat changed before accept");
  tx_step_a: assert property (tv[0] && TX_READY[0] && CORE_CHANNEL_UP && CHANNEL_UP
    |=> !tv[0] || TX_STREAM[0].data == nx($past(TX_STREAM[0].data))) else $error("bad next word");
  tx_seed_a: assert property ($rose(CHANNEL_UP) |=> TX_STREAM[0].data == `LFSR_SEED)
    else $error("first word not seed");
  cnt_sat_a: assert property (DATA_ERR_COUNT == `ERR_CNT_MAX && !PSEL |=> DATA_ERR_COUNT == `ERR_CNT_MAX)
    else $error("count wrapped");
  cnt_cause_a: assert property ($past(RST_N) && !$past(RX_STREAM[0].valid, 2) && !$past(PSEL)
    |-> $stable(DATA_ERR_COUNT)) else $error("count moved without word");
  ufc_cause_a: assert property (UFC_ERR |-> $past(RX_STREAM[1].valid, 2)) else $error("stray ufc flag");
  userk_cause_a: assert property (USER_K_ERR |-> $past(RX_STREAM[3].valid, 2)) else $error("stray k flag");
endmodule : tgc_properties
bind traffic_gen_check tgc_properties #(.LANES(LANES)) props (.SYS_CLK, .RST_N, .CORE_CHANNEL_UP,
  .CORE_HARD_ERR, .CORE_LANE_UP, .CHANNEL_UP, .HARD_ERR, .LANE_UP, .TX_STREAM, .TX_READY, .RX_STREAM,
  .DATA_ERR_COUNT, .UFC_ERR, .USER_K_ERR, .PSEL);
`default_nettype wire

// *** testbench/core_model.sv ***
// loopback model of the link core user interfaces
`timescale 1ns/1ps
`default_nettype none
// ==========
// loopback
module core_model (
  input wire logic clk, // user clock
  input wire logic rst_n, // reset, active low
  input wire tgc_pkg::stream_s [3:0] tx, // beats from generator
  input wire logic [3:0] slow, // random stalls
  input wire logic [3:0] bad, // corrupt accepted word
  output logic [3:0] ready, // ready per channel
  output tgc_pkg::stream_s [3:0] rx // looped beats
);
  // idle data is inverted so a stale word never looks valid
  always_ff @(posedge clk)
    for (int i = 0; i < 4; i++)
    begin
      ready[i] <= rst_n && (!slow[i] || 1'($urandom_range(1)));
      rx[i].valid <= rst_n && tx[i].valid && ready[i];
      rx[i].data <= (tx[i].valid && ready[i]) ? tx[i].data ^ {15'h0000, bad[i]} : ~rx[i].data;
    end
endmodule : core_model
`default_nettype wire

// *** testbench/test_traffic_gen_check.sv ***
// self-checking bench of the traffic generator and checker
`timescale 1ns/1ps
`default_nettype none
`include "tgc_defines.svh"
// ==========
// bench
module test_traffic_gen_check;
  logic SYS_CLK = 0, RST_N = 0, CORE_CHANNEL_UP = 0, CORE_HARD_ERR = 0, CORE_SOFT_ERR = 0, INIT_CLK = 0;
  logic PMA_INIT = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PMA_INIT_CORE, CHANNEL_UP, HARD_ERR, SOFT_ERR;
  logic UFC_ERR, USER_K_ERR, PREADY, PSLVERR, err;
  logic [0:0] CORE_LANE_UP = 0, LANE_UP;
  logic [3:0] TX_READY, slow = 0, bad = 0;
  logic [7:0] DATA_ERR_COUNT;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, q;
  logic [15:0] ex [4];
  wire tgc_pkg::stream_s [3:0] TX_STREAM, RX_STREAM;
  int n_mismatch = 0, num_checks = 0, acc [4], n_ufc = 0, n_uk = 0;
  traffic_gen_check #(.LANES(1)) dut (.SYS_CLK, .RST_N, .CORE_CHANNEL_UP, .CORE_HARD_ERR, .CORE_SOFT_ERR,
    .CORE_LANE_UP, .TX_STREAM, .TX_READY, .RX_STREAM, .INIT_CLK, .PMA_INIT, .PMA_INIT_CORE, .CHANNEL_UP,
    .HARD_ERR, .SOFT_ERR, .LANE_UP, .DATA_ERR_COUNT, .UFC_ERR, .USER_K_ERR, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);
  core_model far (.clk(SYS_CLK), .rst_n(RST_N), .tx(TX_STREAM), .slow, .bad, .ready(TX_READY), .rx(RX_STREAM));
  initial forever #10 SYS_CLK = ~SYS_CLK;
  // slow init clock toggles on falling system edges only
  initial forever #100 INIT_CLK = ~INIT_CLK;
  function automatic logic [15:0] nx(input logic [15:0] x);
    return x[0] ? (x >> 1) ^ `LFSR_TAPS : x >> 1;
  endfunction : nx
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1 && ++n < 9);
    q = PRDATA;
    err = PSLVERR;
    if (n >= 9)
    begin
      n_mismatch++;
      end_sim();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask : apb
  // the transmit sequence restarts at the seed whenever channel-up is low
  always @(posedge SYS_CLK)
  begin
    n_ufc += int'(UFC_ERR === 1'b1);
    n_uk += int'(USER_K_ERR === 1'b1);
    for (int i = 0; i < 4; i++)
      if (CHANNEL_UP !== 1'b1)
        ex[i] = `LFSR_SEED;
      else if (TX_STREAM[i].valid && TX_READY[i])
      begin
        chk(TX_STREAM[i].data, ex[i]);
        ex[i] = nx(ex[i]);
        acc[i]++;
      end
  end
  initial
  begin
    void'($urandom(32'h6763));
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    chk({CHANNEL_UP, TX_STREAM[0].valid, DATA_ERR_COUNT}, 0);
    apb(0, `REG_CTRL, 0);
    chk(q, 32'h0000000F);
    apb(0, 12'h00C, 0);
    chk(q, 32'h00000000);
    chk(err, 1);
    {CORE_HARD_ERR, CORE_SOFT_ERR, CORE_LANE_UP} <= 3'($urandom);
    slow <= 4'($urandom);
    CORE_CHANNEL_UP <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    chk({HARD_ERR, SOFT_ERR, LANE_UP}, {CORE_HARD_ERR, CORE_SOFT_ERR, CORE_LANE_UP});
    apb(0, `REG_STATUS, 0);
    chk(q, {CORE_LANE_UP, 5'h00, CORE_SOFT_ERR, CORE_HARD_ERR, 1'b1});
    repeat (200 + $urandom_range(100)) @(posedge SYS_CLK);
    chk({acc[0] > 0, acc[1] > 0, acc[2] > 0, acc[3] > 0}, 4'hF);
    chk({DATA_ERR_COUNT, n_ufc[3:0], n_uk[3:0]}, 0);
    slow <= 4'h0;
    repeat (4) @(posedge SYS_CLK);
    bad <= 4'hE;
    @(posedge SYS_CLK);
    bad <= 4'h1;
    @(posedge SYS_CLK);
    bad <= 4'h0;
    repeat (6) @(posedge SYS_CLK);
    chk({DATA_ERR_COUNT, n_ufc[3:0], n_uk[3:0]}, 16'h0111);
    apb(0, `REG_ERR, 0);
    chk({q[10], q[7:0]}, 9'h101);
    bad <= 4'h1;
    repeat (300) @(posedge SYS_CLK);
    bad <= 4'h0;
    repeat (6) @(posedge SYS_CLK);
    chk(DATA_ERR_COUNT, 8'hFF);
    apb(1, `REG_ERR, 32'h00000401);
    apb(0, `REG_ERR, 0);
    chk(q[10:0], 0);
    apb(1, `REG_CTRL, 32'h0000000E);
    repeat (3) @(posedge SYS_CLK);
    chk({TX_STREAM[0].valid, TX_STREAM[1].valid}, 2'b01);
    RST_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    apb(0, `REG_CTRL, 0);
    chk(q, 32'h0000000F);
    CORE_CHANNEL_UP <= 1'b0;
    repeat (5) @(posedge SYS_CLK);
    chk({TX_STREAM[3].valid, TX_STREAM[2].valid, TX_STREAM[1].valid, TX_STREAM[0].valid}, 0);
    CORE_CHANNEL_UP <= 1'b1;
    repeat (60) @(posedge SYS_CLK);
    chk({DATA_ERR_COUNT, n_ufc[3:0], n_uk[3:0]}, 16'h0011);
    PMA_INIT <= 1'b1;
    repeat (20) @(posedge SYS_CLK);
    chk(PMA_INIT_CORE, 0);
    for (int i = 0; i < 100 && PMA_INIT_CORE !== 1'b1; i++) @(posedge SYS_CLK);
    chk(PMA_INIT_CORE, 1);
    PMA_INIT <= 1'b0;
    for (int i = 0; i < 100 && PMA_INIT_CORE !== 1'b0; i++) @(posedge SYS_CLK);
    chk(PMA_INIT_CORE, 0);
    end_sim();
  end
endmodule : test_traffic_gen_check
`default_nettype wire
